// ---- hseq_params.svh ----
// Constants of the homing sequencer: status codes, method ranges, timing
`ifndef HSEQ_PARAMS_SVH
`define HSEQ_PARAMS_SVH
// Status word bits 13,12,10 as a 3-bit code
`define HSEQ_ST_RUN 3'h0
`define HSEQ_ST_IDLE 3'h1
`define HSEQ_ST_CONF 3'h2
`define HSEQ_ST_DONE 3'h3
`define HSEQ_ST_ERR_MOV 3'h4
`define HSEQ_ST_ERR_STOP 3'h5
// Millisecond time base
`define HSEQ_CLK_HZ 125000000
`define HSEQ_MS_NS 1000000
`define HSEQ_CLK_NS 8
`define HSEQ_MS_CYC (`HSEQ_MS_NS / `HSEQ_CLK_NS)
// Method numbers
`define HSEQ_M_IDX_ONLY_LO 8'sd33
`define HSEQ_M_IDX_ONLY_HI 8'sd34
`define HSEQ_M_HERE 8'sd35
`define HSEQ_M_NOIDX_OFS 8'sd16
`endif

// ---- hseq_pkg.sv ----
// Types of the homing sequencer
`default_nettype none
package hseq_pkg;
    // Sequencer states, one-hot
    typedef enum logic [6:0] {
        HSEQ_IDLE = 7'h01,
        HSEQ_SEEK_SW = 7'h02,
        HSEQ_BACKOFF = 7'h04,
        HSEQ_SEEK_IDX = 7'h08,
        HSEQ_DWELL = 7'h10,
        HSEQ_DONE = 7'h20,
        HSEQ_FAIL = 7'h40
    } hseq_state_t;
    // What the reference edge is taken from
    typedef enum logic [1:0] {
        HSEQ_REF_NEG = 2'h0,
        HSEQ_REF_POS = 2'h1,
        HSEQ_REF_HOME = 2'h2,
        HSEQ_REF_NONE = 2'h3
    } hseq_ref_t;
endpackage
`default_nettype wire

// ---- hseq_sequencer.sv ----
// Homing sequencer: method decode, search sequence and status code
// Notes on behaviour
// - Bits 13,12,10: 000 running, 001 idle, 010 confirmed, 011 done.
// - Homing error gives 100 while turning, 101 at standstill.
// - Bit 12 is set only after a fully completed run since restart.
// - Bit 12 clears during later runs and on error until next completion.
// - Reference shift is the distance from own zero to machine reference.
// - Method number picks edge, block or switch, index, start direction.
// - 1..14, 33, 34 use index; 17..30 same profiles without index.
// - Block methods -1,-2,-7..-14 with index; -17,-18,-23..-30 without.
// - Block homing runs only under closed-loop control.
// - Block contact when motor current exceeds stall current threshold.
// - After block contact keep pushing for the dwell time in ms.
// - Switch search at switch speed, index search at index speed.
// - One ramp rate serves both acceleration and braking.
// - Method 1 negative limit plus index; 2 positive limit plus index.
// - Methods 3,4 home left edge; 5,6 home right edge; both plus index.
// - 7..14 home switch plus index; 7..10 positive, 11..14 negative.
// - Method 17 negative limit, 18 positive limit, no index.
// - Methods 19..22 act as 3..6 without index.
// - 23..30 home switch without index; 23..26 positive, 27..30 negative.
// - Methods 33, 34 reference to the next index pulse only.
// - Method 35 takes present position, even when drive not active.
// - Command bit 4 high starts; run lasts until done, error or bit cleared.
`include "hseq_params.svh"
`default_nettype none
module hseq_sequencer #(
    parameter int POS_W = 32,
    parameter int SPD_W = 32,
    parameter int CUR_W = 16
)(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Host settings and command
    input wire logic start_bit,
    input wire logic signed [7:0] method,
    input wire logic signed [POS_W-1:0] ref_shift,
    input wire logic [SPD_W-1:0] switch_speed,
    input wire logic [SPD_W-1:0] index_speed,
    input wire logic [SPD_W-1:0] ramp_rate,
    input wire logic [CUR_W-1:0] stall_current_threshold,
    input wire logic [15:0] stall_dwell_ms,
    input wire logic closed_loop,
    input wire logic drive_active,
    // Drive feedback
    input wire logic [CUR_W-1:0] motor_current,
    input wire logic standstill,
    // Pins
    input wire logic neg_limit_pin,
    input wire logic pos_limit_pin,
    input wire logic home_pin,
    input wire logic index_pin,
    // Motion demand
    output logic move_en,
    output logic move_dir_pos,
    output logic [SPD_W-1:0] move_speed,
    output logic [SPD_W-1:0] move_ramp,
    output logic pos_load,
    output logic signed [POS_W-1:0] pos_load_value,
    // Status word bits 13,12,10
    output logic [2:0] home_status
);
    // Elaboration check: refuse widths the logic cannot serve
    if (POS_W < 2 || SPD_W < 1 || CUR_W < 1)
    begin : g_bad_width
        $error("hseq_sequencer: width parameter too small");
    end

    // ----------------------------------------------------------------
    // Method decode
    // ----------------------------------------------------------------
    // Valid check on a signed method, block flag from its sign
    function automatic logic meth_ok(input logic signed [7:0] m);
        logic signed [7:0] a;
        a = (m < 0) ? -m : m;
        if (m < 0)
            meth_ok = (a >= 1 && a <= 2) || (a >= 7 && a <= 14) || a == 17 ||
                      a == 18 || (a >= 23 && a <= 30);
        else
            meth_ok = (a >= 1 && a <= 14) || (a >= 17 && a <= 30) ||
                      (a >= 33 && a <= 35);
    endfunction

    logic signed [7:0] mag;
    logic signed [7:0] base;
    logic use_idx;
    logic blk;
    hseq_pkg::hseq_ref_t ref_src;
    logic dir_pos;
    logic rising_edge_ref;

    // Fold 17..30 onto 1..14; index use from range
    always_comb
    begin
        blk = method < 0;
        mag = blk ? -method : method;
        use_idx = (mag <= 14) || mag == `HSEQ_M_IDX_ONLY_LO ||
                  mag == `HSEQ_M_IDX_ONLY_HI;
        base = (mag >= 17 && mag <= 30) ? mag - `HSEQ_M_NOIDX_OFS : mag;
        ref_src = hseq_pkg::HSEQ_REF_HOME;
        dir_pos = 1'b0;
        rising_edge_ref = 1'b1;
        if (base == 1)
            ref_src = hseq_pkg::HSEQ_REF_NEG;
        else if (base == 2)
        begin
            ref_src = hseq_pkg::HSEQ_REF_POS;
            dir_pos = 1'b1;
        end
        else if (base >= 3 && base <= 6)
        begin
            // odd methods start positive towards the edge
            dir_pos = base[0];
            // Left edge rises moving up, falls moving down; right reversed
            rising_edge_ref = (base <= 4) ? base[0] : !base[0];
        end
        else if (base >= 7 && base <= 14)
        begin
            // 7..10 go positive first, 11..14 negative
            dir_pos = (base <= 10);
            rising_edge_ref = base[0];
        end
        else if (mag == `HSEQ_M_IDX_ONLY_LO || mag == `HSEQ_M_IDX_ONLY_HI)
        begin
            ref_src = hseq_pkg::HSEQ_REF_NONE;
            dir_pos = (mag == `HSEQ_M_IDX_ONLY_HI);
        end
    end

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [3:0] pin_s1_reg;
    logic [3:0] pin_s2_reg;
    logic [3:0] pin_s3_reg;
    logic [3:0] pin_reg;
    logic [3:0] pin_next;
    // Three stages; a change counts once stages two and three agree
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pin_s1_reg <= 4'h0;
            pin_s2_reg <= 4'h0;
            pin_s3_reg <= 4'h0;
            pin_reg <= 4'h0;
        end
        else
        begin
            pin_s1_reg <= {index_pin, home_pin, pos_limit_pin, neg_limit_pin};
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
            pin_reg <= pin_next;
        end
    end
    always_comb
    begin
        for (int i = 0; i < 4; i++)
            pin_next[i] = (pin_s2_reg[i] == pin_s3_reg[i]) ? pin_s3_reg[i]
                                                          : pin_reg[i];
    end

    logic idx_rise;
    logic home_edge;
    logic ref_hit;
    logic wrong_limit;
    logic stall;
    logic dwell_over;
    assign idx_rise = pin_next[3] & ~pin_reg[3];
    assign home_edge = rising_edge_ref ? (pin_next[2] & ~pin_reg[2])
                                       : (~pin_next[2] & pin_reg[2]);
    assign stall = motor_current > stall_current_threshold;

    // ----------------------------------------------------------------
    // Sequence
    // ----------------------------------------------------------------
    hseq_pkg::hseq_state_t state_reg;
    logic ever_done_reg;
    logic [15:0] ms_cnt_reg;
    logic [$clog2(`HSEQ_MS_CYC+1)-1:0] tick_cnt_reg;

    // Reference event of the seek phase
    always_comb
    begin
        unique case (ref_src)
            hseq_pkg::HSEQ_REF_NEG: ref_hit = blk ? stall : pin_reg[0];
            hseq_pkg::HSEQ_REF_POS: ref_hit = blk ? stall : pin_reg[1];
            hseq_pkg::HSEQ_REF_HOME: ref_hit = home_edge;
            hseq_pkg::HSEQ_REF_NONE: ref_hit = 1'b1;
        endcase
        // Hitting the far end while seeking the home edge is an error
        wrong_limit = (ref_src == hseq_pkg::HSEQ_REF_HOME) &&
                      (blk ? stall : (move_dir_pos ? pin_reg[1]
                                                   : pin_reg[0]));
    end
    assign dwell_over = ms_cnt_reg >= stall_dwell_ms;

    // Main state machine; start level gates every active state
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            state_reg <= hseq_pkg::HSEQ_IDLE;
        else if (!start_bit)
            state_reg <= hseq_pkg::HSEQ_IDLE;
        else
            unique case (state_reg)
                hseq_pkg::HSEQ_IDLE:
                    if (!meth_ok(method))
                        state_reg <= hseq_pkg::HSEQ_IDLE;
                    else if (method == `HSEQ_M_HERE)
                        state_reg <= hseq_pkg::HSEQ_DONE;
                    else if (!drive_active || (blk && !closed_loop))
                        state_reg <= hseq_pkg::HSEQ_FAIL;
                    else
                        state_reg <= hseq_pkg::HSEQ_SEEK_SW;
                hseq_pkg::HSEQ_SEEK_SW:
                    if (wrong_limit)
                        state_reg <= hseq_pkg::HSEQ_FAIL;
                    else if (ref_hit && blk && ref_src !=
                             hseq_pkg::HSEQ_REF_HOME)
                        state_reg <= hseq_pkg::HSEQ_DWELL;
                    else if (ref_hit)
                        state_reg <= use_idx ? hseq_pkg::HSEQ_SEEK_IDX
                                             : hseq_pkg::HSEQ_DONE;
                hseq_pkg::HSEQ_DWELL:
                    if (dwell_over)
                        state_reg <= use_idx ? hseq_pkg::HSEQ_SEEK_IDX
                                             : hseq_pkg::HSEQ_DONE;
                hseq_pkg::HSEQ_BACKOFF:
                    state_reg <= hseq_pkg::HSEQ_SEEK_IDX;
                hseq_pkg::HSEQ_SEEK_IDX:
                    if (idx_rise)
                        state_reg <= hseq_pkg::HSEQ_DONE;
                hseq_pkg::HSEQ_DONE:
                    state_reg <= hseq_pkg::HSEQ_DONE;
                hseq_pkg::HSEQ_FAIL:
                    state_reg <= hseq_pkg::HSEQ_FAIL;
                default:
                    state_reg <= hseq_pkg::HSEQ_IDLE;
            endcase
    end

    // Dwell timer: millisecond prescaler and count
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            tick_cnt_reg <= '0;
            ms_cnt_reg <= 16'h0;
        end
        else if (state_reg != hseq_pkg::HSEQ_DWELL)
        begin
            tick_cnt_reg <= '0;
            ms_cnt_reg <= 16'h0;
        end
        else if (tick_cnt_reg == ($bits(tick_cnt_reg))'(`HSEQ_MS_CYC - 1))
        begin
            tick_cnt_reg <= '0;
            ms_cnt_reg <= ms_cnt_reg + 16'h1;
        end
        else
            tick_cnt_reg <= tick_cnt_reg + 1'b1;
    end

    // Homed flag: set on completion, cleared by a new run or error
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            ever_done_reg <= 1'b0;
        else if (state_reg == hseq_pkg::HSEQ_DONE)
            ever_done_reg <= 1'b1;
        else if (state_reg != hseq_pkg::HSEQ_IDLE)
            ever_done_reg <= 1'b0;
    end

    // Position load, one pulse on entry into done
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pos_load <= 1'b0;
            pos_load_value <= '0;
        end
        else
        begin
            pos_load <= start_bit && state_reg != hseq_pkg::HSEQ_DONE &&
                        state_reg != hseq_pkg::HSEQ_FAIL &&
                        ((state_reg == hseq_pkg::HSEQ_SEEK_IDX && idx_rise) ||
                         (state_reg == hseq_pkg::HSEQ_IDLE &&
                          method == `HSEQ_M_HERE) ||
                         (state_reg == hseq_pkg::HSEQ_SEEK_SW && ref_hit &&
                          !wrong_limit && !use_idx &&
                          !(blk && ref_src != hseq_pkg::HSEQ_REF_HOME)) ||
                         (state_reg == hseq_pkg::HSEQ_DWELL && dwell_over &&
                          !use_idx));
            pos_load_value <= ref_shift;
        end
    end

    // Motion demand registers
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            move_en <= 1'b0;
            move_dir_pos <= 1'b0;
            move_speed <= '0;
            move_ramp <= '0;
        end
        else
        begin
            move_en <= start_bit && (state_reg == hseq_pkg::HSEQ_SEEK_SW ||
                       state_reg == hseq_pkg::HSEQ_SEEK_IDX ||
                       state_reg == hseq_pkg::HSEQ_DWELL);
            if (state_reg == hseq_pkg::HSEQ_IDLE)
                move_dir_pos <= dir_pos;
            else if (state_reg == hseq_pkg::HSEQ_DWELL && dwell_over)
                move_dir_pos <= ~move_dir_pos; // back off the block
            move_speed <= (state_reg == hseq_pkg::HSEQ_SEEK_IDX) ?
                          index_speed : switch_speed;
            move_ramp <= ramp_rate;
        end
    end

    // Status code from state, homed flag and standstill
    always_comb
    begin
        unique case (state_reg)
            hseq_pkg::HSEQ_IDLE: home_status = `HSEQ_ST_IDLE;
            hseq_pkg::HSEQ_DONE: home_status = `HSEQ_ST_DONE;
            hseq_pkg::HSEQ_FAIL: home_status = standstill ?
                `HSEQ_ST_ERR_STOP : `HSEQ_ST_ERR_MOV;
            default: home_status = ever_done_reg ? `HSEQ_ST_CONF
                                                 : `HSEQ_ST_RUN;
        endcase
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    bad_method_a: assert property (
        @(posedge clk) disable iff (!nrst)
        state_reg == hseq_pkg::HSEQ_IDLE && !meth_ok(method) |=>
        state_reg == hseq_pkg::HSEQ_IDLE &&
        home_status == `HSEQ_ST_IDLE)
        else $error("bad method left idle");
    stop_cmd_a: assert property (
        @(posedge clk) disable iff (!nrst)
        !start_bit |=> state_reg == hseq_pkg::HSEQ_IDLE)
        else $error("run not ended by cleared start");
    err_code_a: assert property (
        @(posedge clk) disable iff (!nrst)
        state_reg == hseq_pkg::HSEQ_FAIL |-> home_status[2])
        else $error("error code missing");
    done_load_a: assert property (
        @(posedge clk) disable iff (!nrst)
        $rose(state_reg == hseq_pkg::HSEQ_DONE) |-> pos_load)
        else $error("no position load on completion");
    idx_speed_a: assert property (
        @(posedge clk) disable iff (!nrst)
        state_reg == hseq_pkg::HSEQ_SEEK_IDX ##1
        state_reg == hseq_pkg::HSEQ_SEEK_IDX |-> move_speed ==
        $past(index_speed))
        else $error("wrong index speed");
    homed_flag_a: assert property (
        @(posedge clk) disable iff (!nrst)
        state_reg == hseq_pkg::HSEQ_FAIL |=> !ever_done_reg)
        else $error("homed flag survived error");
endmodule
`default_nettype wire

// ---- hseq_axis_model.sv ----
// Axis model: switches, encoder index, motor current and standstill
`default_nettype none
module hseq_axis_model #(
    parameter int LIM = 64,
    parameter int HOME_W = 12,
    parameter int IDX_P = 16,
    parameter int STEP = 8
)(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Motion demand from the sequencer
    input wire logic move_en,
    input wire logic move_dir_pos,
    // Pins and feedback
    output logic neg_limit_pin,
    output logic pos_limit_pin,
    output logic home_pin,
    output logic index_pin,
    output logic standstill,
    output logic [15:0] motor_current
);
    timeunit 1ns;
    timeprecision 1ps;
    int pos;
    int div;
    // One count per STEP cycles; the mechanical block stops travel
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pos <= 20;
            div <= 0;
        end
        else if (move_en && div == STEP - 1)
        begin
            div <= 0;
            if (move_dir_pos && pos < LIM)
                pos <= pos + 1;
            else if (!move_dir_pos && pos > -LIM)
                pos <= pos - 1;
        end
        else
            div <= move_en ? div + 1 : 0;
    end
    // Motor stops one cycle after demand drops
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            standstill <= 1'b1;
        else
            standstill <= !move_en;
    end
    // Limit switches sit a few counts before each block
    always_comb
    begin
        neg_limit_pin = pos <= -LIM + 4;
        pos_limit_pin = pos >= LIM - 4;
        home_pin = pos >= -4 && pos <= HOME_W;
        index_pin = pos % IDX_P == 0;
    end
    // Current rises when pushing against a block
    always_comb
    begin
        if (move_en && (pos == LIM || pos == -LIM))
            motor_current = 16'h0800;
        else
            motor_current = move_en ? 16'h0100 : 16'h0010;
    end
endmodule
`default_nettype wire

// ---- hseq_sequencer_tb_top.sv ----
// Self-checking testbench of the homing sequencer
`include "hseq_params.svh"
`default_nettype none
module hseq_sequencer_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic start_bit = 1'b0;
    logic signed [7:0] method = 8'sh00;
    logic signed [31:0] ref_shift = 32'sh0;
    logic [31:0] switch_speed = 32'h0000_0040;
    logic [31:0] index_speed = 32'h0000_0008;
    logic [31:0] ramp_rate = 32'h0000_0100;
    logic [15:0] stall_current_threshold = 16'h0400;
    logic [15:0] stall_dwell_ms = 16'h0001;
    logic closed_loop = 1'b1;
    logic drive_active = 1'b0;
    logic [15:0] motor_current;
    logic standstill, neg_lim, pos_lim, home_sw, index_p;
    logic move_en, move_dir_pos, pos_load;
    logic [31:0] move_speed, move_ramp;
    logic signed [31:0] pos_load_value;
    logic [2:0] home_status;
    int miscompares = 0;
    int checks_done = 0;
    int loads = 0;
    logic [31:0] load_val;
    logic homed = 1'b0;
    // ------------------------------------------------------------
    // Clock, design and axis
    // ------------------------------------------------------------
    always #4 clk = ~clk;
    hseq_sequencer i_dut (.clk(clk), .nrst(nrst), .start_bit(start_bit),
        .method(method), .ref_shift(ref_shift),
        .switch_speed(switch_speed), .index_speed(index_speed),
        .ramp_rate(ramp_rate),
        .stall_current_threshold(stall_current_threshold),
        .stall_dwell_ms(stall_dwell_ms), .closed_loop(closed_loop),
        .drive_active(drive_active), .motor_current(motor_current),
        .standstill(standstill), .neg_limit_pin(neg_lim),
        .pos_limit_pin(pos_lim), .home_pin(home_sw), .index_pin(index_p),
        .move_en(move_en), .move_dir_pos(move_dir_pos),
        .move_speed(move_speed), .move_ramp(move_ramp),
        .pos_load(pos_load), .pos_load_value(pos_load_value),
        .home_status(home_status));
    hseq_axis_model i_axis (.clk(clk), .nrst(nrst), .move_en(move_en),
        .move_dir_pos(move_dir_pos), .neg_limit_pin(neg_lim),
        .pos_limit_pin(pos_lim), .home_pin(home_sw), .index_pin(index_p),
        .standstill(standstill), .motor_current(motor_current));
    // One-cycle pulse, caught mid-cycle where it has settled
    always @(negedge clk)
    begin
        if (pos_load === 1'b1)
        begin
            loads++;
            load_val = pos_load_value;
        end
    end
    // ------------------------------------------------------------
    // Compare, run and verdict tasks
    // ------------------------------------------------------------
    task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_status(input logic [2:0] got, input logic [2:0] exp);
        cmp_val({29'h0, got}, {29'h0, exp});
    endtask
    task automatic print_verdict;
        $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // dir: 0 neg, 1 pos, 2 any; idx: 0 none, 1 after switch, 3 only, 2 any
    task automatic run(input logic signed [7:0] m, input logic [2:0] exp,
                       input int dir, input int idx);
        int n;
        int loads0;
        logic saw_idx;
        logic seek;
        logic [2:0] st_exp;
        logic [31:0] spd;
        begin
            loads0 = loads;
            saw_idx = 1'b0;
            seek = m != 8'sd35 && drive_active && closed_loop &&
                   exp != `HSEQ_ST_IDLE;
            n = 0;
            method = m;
            ref_shift = 32'sh100 + m;
            start_bit = 1'b1;
            do
            begin
                @(negedge clk);
                n++;
                if (move_en === 1'b1 && move_speed === index_speed)
                    saw_idx = 1'b1;
                // A run after an earlier success shows 010 for one cycle
                if (n <= 2 && seek && homed)
                begin
                    st_exp = (n == 1) ? `HSEQ_ST_CONF : `HSEQ_ST_RUN;
                    cmp_status(home_status, st_exp);
                end
                if (n == 4 && home_status === `HSEQ_ST_RUN)
                begin
                    cmp_val(move_en, 1'b1);
                    cmp_val(move_ramp, ramp_rate);
                    spd = (idx == 3) ? index_speed : switch_speed;
                    cmp_val(move_speed, spd);
                    if (dir != 2)
                        cmp_val(move_dir_pos, dir[0]);
                end
            end
            while ((home_status === `HSEQ_ST_RUN ||
                    home_status === `HSEQ_ST_CONF) && n < 30000);
            while (home_status === `HSEQ_ST_ERR_MOV && n < 30010)
            begin
                @(negedge clk);
                n++;
            end
            // Let the load monitor see the final cycle first
            @(negedge clk);
            cmp_status(home_status, exp);
            if (exp === `HSEQ_ST_DONE)
            begin
                cmp_val(loads - loads0, 1);
                cmp_val(load_val, ref_shift);
                if (idx != 2)
                    cmp_val(saw_idx, idx != 0);
            end
            else
                cmp_val(loads - loads0, 0);
            if (exp === `HSEQ_ST_DONE)
                homed = 1'b1;
            else if (exp[2])
                homed = 1'b0;
            start_bit = 1'b0;
            repeat (3) @(negedge clk);
            $display("test method %0d done", m);
        end
    endtask
    // ------------------------------------------------------------
    // Test sequence and watchdog
    // ------------------------------------------------------------
    initial
    begin
        repeat (5) @(negedge clk);
        nrst = 1'b1;
        cmp_status(home_status, `HSEQ_ST_IDLE);
        run(8'sd0, `HSEQ_ST_IDLE, 2, 2);
        run(8'sd15, `HSEQ_ST_IDLE, 2, 2);
        run(8'sd36, `HSEQ_ST_IDLE, 2, 2);
        run(-8'sd3, `HSEQ_ST_IDLE, 2, 2);
        run(8'sd35, `HSEQ_ST_DONE, 2, 2);
        run(8'sd17, `HSEQ_ST_ERR_STOP, 2, 2);
        drive_active = 1'b1;
        // Order keeps each run starting on the side its profile needs
        run(8'sd1, `HSEQ_ST_DONE, 0, 1);
        run(8'sd3, `HSEQ_ST_DONE, 1, 1);
        run(8'sd5, `HSEQ_ST_DONE, 1, 1);
        // Upward seek right of the home switch runs into the far limit
        run(8'sd7, `HSEQ_ST_ERR_STOP, 1, 2);
        run(8'sd11, `HSEQ_ST_DONE, 0, 1);
        run(8'sd2, `HSEQ_ST_DONE, 1, 1);
        run(8'sd27, `HSEQ_ST_DONE, 0, 0);
        run(8'sd21, `HSEQ_ST_DONE, 1, 0);
        run(8'sd18, `HSEQ_ST_DONE, 1, 0);
        run(8'sd17, `HSEQ_ST_DONE, 0, 0);
        run(8'sd19, `HSEQ_ST_DONE, 1, 0);
        run(8'sd33, `HSEQ_ST_DONE, 0, 3);
        run(8'sd23, `HSEQ_ST_DONE, 1, 0);
        run(8'sd34, `HSEQ_ST_DONE, 1, 3);
        // Negative number asks for block homing
        stall_dwell_ms = 16'h0000;
        run(-8'sd17, `HSEQ_ST_DONE, 0, 0);
        stall_dwell_ms = 16'h0001;
        run(8'sd7, `HSEQ_ST_DONE, 1, 1);
        // Open loop block request must be refused with an error
        closed_loop = 1'b0;
        run(-8'sd17, `HSEQ_ST_ERR_STOP, 2, 2);
        closed_loop = 1'b1;
        run(8'sd35, `HSEQ_ST_DONE, 2, 2);
        // Abort by clearing the start bit in mid-run
        method = 8'sd17;
        start_bit = 1'b1;
        repeat (6) @(negedge clk);
        start_bit = 1'b0;
        repeat (4) @(negedge clk);
        cmp_status(home_status, `HSEQ_ST_IDLE);
        cmp_val(move_en, 1'b0);
        $display("test abort done");
        print_verdict();
    end
    // Cut a hang short well past the expected run length
    initial
    begin
        #(8 * 20000);
        miscompares++;
        print_verdict();
    end
endmodule
`default_nettype wire
